// File: logic/ddrc_ctrl.sv
// controller that drives a four-bank DDR SDRAM through its command and data pins
`timescale 1ns/1ps
module ddrc_ctrl #(
    parameter int DQ_W = 8,
    parameter int ADDR_W = 13
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire ddrc_pkg::ddrc_op_t cmdOp,
    input wire logic [ddrc_pkg::BA_W-1:0] cmdBank,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic cmdAuto,
    output logic cmdAck,
    input wire logic [DQ_W-1:0] wrData,
    output logic wrPull,
    output logic [2*DQ_W-1:0] rdData,
    output logic rdValid,
    output logic [ddrc_pkg::NUM_BANKS-1:0] bankOpen,
    output logic ck,
    output logic ckN,
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic [ddrc_pkg::BA_W-1:0] ba,
    output logic [ADDR_W-1:0] addr,
    output logic [DQ_W-1:0] dqOut,
    output logic dqOe,
    output logic dqsOut,
    output logic dqsOe,
    input wire logic [DQ_W-1:0] dqIn,
    input wire logic dqsClk
);
    import ddrc_pkg::*;

    logic ck_reg;
    logic ckN_reg;
    logic slot;
    logic legal;
    logic issue;
    logic csN_reg;
    logic [2:0] pins_reg;
    logic [BA_W-1:0] ba_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic cmdAck_reg;
    logic [2:0] blCode_reg;
    logic bt_reg;
    logic [2:0] clCode_reg;
    logic [CNT_W-1:0] burstCk;
    logic [CNT_W-1:0] clRu;
    logic [CNT_W-1:0] rdBusy_reg;
    logic rdAuto_reg;
    logic [CNT_W-1:0] rrd_reg;
    logic [CNT_W-1:0] wrStage_reg;
    logic [CNT_W-1:0] wrStage_next;
    logic [CNT_W-1:0] wrLast;
    logic [CNT_W-1:0] wrLd;
    logic [CNT_W-1:0] autoLd;
    logic wrPull_reg;
    logic [DQ_W-1:0] dqOut_reg;
    logic dqOe_reg;
    logic dqsOut_reg;
    logic dqsOe_reg;
    logic [NUM_BANKS-1:0] openV;
    logic [NUM_BANKS-1:0] actOkV;
    logic [NUM_BANKS-1:0] colOkV;
    logic [NUM_BANKS-1:0] preOkV;
    logic [NUM_BANKS-1:0] bankOpen_reg;
    logic [2*DQ_W-1:0] pairData;
    logic pairToggle;
    logic rdTogS1_reg;
    logic rdTogS2_reg;
    logic rdTogS3_reg;
    logic [2*DQ_W-1:0] rdData_reg;
    logic rdValid_reg;

    // CK is clk divided by two; commands change where CK falls
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ck_reg <= 1'b0;
            ckN_reg <= 1'b1;
        end else begin
            ck_reg <= ~ck_reg;
            ckN_reg <= ck_reg;
        end
    end

    assign slot = ck_reg;
    assign burstCk = burst_ck(blCode_reg);
    assign clRu = cl_ru(clCode_reg);
    assign wrLast = {burstCk[CNT_W-2:0], 1'b1};
    assign wrLd = CNT_W'(burstCk + T_WR_CNT);
    assign autoLd = (cmdOp == OP_WRITE) ? wrLd : CNT_W'(burstCk - CNT_W'(1));

    // command legality against bank state, bus use and spacing
    always_comb begin
        case (cmdOp)
            OP_NOP: legal = 1'b1;
            OP_ACT: legal = actOkV[cmdBank] && rrd_reg == '0;
            OP_READ: legal = colOkV[cmdBank] && wrStage_reg == '0;
            OP_WRITE: legal = colOkV[cmdBank] && rdBusy_reg == '0 && !rdAuto_reg
                && wrStage_reg == '0;
            OP_PRE: legal = preOkV[cmdBank];
            OP_PREALL: legal = &(preOkV | ~openV);
            OP_BST: legal = rdBusy_reg != '0 && !rdAuto_reg;
            OP_MRS: legal = openV == '0 && &actOkV && rdBusy_reg == '0
                && wrStage_reg == '0;
            default: legal = 1'b0;
        endcase
    end

    assign issue = slot && cmdValid && legal;

    // command, bank and address pins, held for one CK cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            csN_reg <= 1'b1;
            pins_reg <= PIN_NOP;
            ba_reg <= '0;
            addr_reg <= '0;
        end else if (issue) begin
            csN_reg <= 1'b0;
            ba_reg <= cmdBank;
            addr_reg <= cmdAddr;
            case (cmdOp)
                OP_ACT: pins_reg <= PIN_ACT;
                OP_READ: begin
                    pins_reg <= PIN_RD;
                    addr_reg[AP_BIT] <= cmdAuto;
                end
                OP_WRITE: begin
                    pins_reg <= PIN_WR;
                    addr_reg[AP_BIT] <= cmdAuto;
                end
                OP_PRE: begin
                    pins_reg <= PIN_PRE;
                    addr_reg[AP_BIT] <= 1'b0;
                end
                OP_PREALL: begin
                    pins_reg <= PIN_PRE;
                    addr_reg[AP_BIT] <= 1'b1;
                end
                OP_BST: pins_reg <= PIN_BST;
                OP_MRS: begin
                    pins_reg <= PIN_MRS;
                    ba_reg <= '0;
                end
                default: pins_reg <= PIN_NOP;
            endcase
        end else if (slot) begin
            csN_reg <= 1'b1;
            pins_reg <= PIN_NOP;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmdAck_reg <= 1'b0;
        end else begin
            cmdAck_reg <= issue;
        end
    end

    // host copy of the mode register fields
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            blCode_reg <= BL_RESET;
            bt_reg <= 1'b0;
            clCode_reg <= CL_RESET;
        end else if (issue && cmdOp == OP_MRS) begin
            blCode_reg <= cmdAddr[MR_BL_LSB +: MR_FIELD_W];
            bt_reg <= cmdAddr[MR_BT_BIT];
            clCode_reg <= cmdAddr[MR_CL_LSB +: MR_FIELD_W];
        end
    end

    // read bus busy until the last word or until a burst stop takes effect
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdBusy_reg <= '0;
            rdAuto_reg <= 1'b0;
        end else if (issue && cmdOp == OP_READ) begin
            rdBusy_reg <= CNT_W'(clRu + burstCk - CNT_W'(1));
            rdAuto_reg <= cmdAuto;
        end else if (issue && cmdOp == OP_BST) begin
            rdBusy_reg <= CNT_W'(clRu - CNT_W'(1));
        end else if (slot && rdBusy_reg != '0) begin
            rdBusy_reg <= rdBusy_reg - CNT_W'(1);
        end else if (rdBusy_reg == '0) begin
            rdAuto_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rrd_reg <= '0;
        end else if (issue && cmdOp == OP_ACT) begin
            rrd_reg <= T_RRD_LD;
        end else if (slot && rrd_reg != '0) begin
            rrd_reg <= rrd_reg - CNT_W'(1);
        end
    end

    // write burst: stage 1 preamble, stages 2 to wrLast one word each
    always_comb begin
        if (issue && cmdOp == OP_WRITE) begin
            wrStage_next = CNT_W'(1);
        end else if (wrStage_reg == '0 || wrStage_reg == wrLast) begin
            wrStage_next = '0;
        end else begin
            wrStage_next = wrStage_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrStage_reg <= '0;
            wrPull_reg <= 1'b0;
            dqOut_reg <= '0;
            dqOe_reg <= 1'b0;
        end else begin
            wrStage_reg <= wrStage_next;
            wrPull_reg <= wrStage_next >= CNT_W'(2);
            if (wrStage_reg >= CNT_W'(2)) begin
                dqOut_reg <= wrData;
                dqOe_reg <= 1'b1;
            end else begin
                dqOe_reg <= 1'b0;
            end
        end
    end

    // strobe moves half a clk after each word, centred in its data eye
    always_ff @(negedge clk or posedge reset) begin
        if (reset) begin
            dqsOut_reg <= 1'b0;
            dqsOe_reg <= 1'b0;
        end else begin
            dqsOe_reg <= wrStage_reg != '0 || dqOe_reg;
            dqsOut_reg <= dqOe_reg ? ~dqsOut_reg : 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
            logic sel;
            assign sel = issue && cmdBank == BA_W'(gi);
            ddrc_bank_timer u_timer (
                .clk(clk),
                .reset(reset),
                .slot(slot),
                .actHit(sel && cmdOp == OP_ACT),
                .preHit((sel && cmdOp == OP_PRE) || (issue && cmdOp == OP_PREALL)),
                .colHit(sel && (cmdOp == OP_READ || cmdOp == OP_WRITE)),
                .wrHit(sel && cmdOp == OP_WRITE),
                .autoHit(sel && cmdAuto && (cmdOp == OP_READ || cmdOp == OP_WRITE)),
                .wrLd(wrLd),
                .autoLd(autoLd),
                .isOpen(openV[gi]),
                .actOk(actOkV[gi]),
                .colOk(colOkV[gi]),
                .preOk(preOkV[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bankOpen_reg <= '0;
        end else begin
            bankOpen_reg <= openV;
        end
    end

    ddrc_rd_capture #(
        .DQ_W(DQ_W)
    ) u_capture (
        .dqsClk(dqsClk),
        .reset(reset),
        .dqIn(dqIn),
        .pairData(pairData),
        .pairToggle(pairToggle)
    );

    // toggle crossing from the strobe domain; pair data is stable by then
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdTogS1_reg <= 1'b0;
            rdTogS2_reg <= 1'b0;
            rdTogS3_reg <= 1'b0;
            rdData_reg <= '0;
            rdValid_reg <= 1'b0;
        end else begin
            rdTogS1_reg <= pairToggle;
            rdTogS2_reg <= rdTogS1_reg;
            rdTogS3_reg <= rdTogS2_reg;
            rdValid_reg <= rdTogS2_reg != rdTogS3_reg;
            if (rdTogS2_reg != rdTogS3_reg) begin
                rdData_reg <= pairData;
            end
        end
    end

    assign cmdAck = cmdAck_reg;
    assign wrPull = wrPull_reg;
    assign rdData = rdData_reg;
    assign rdValid = rdValid_reg;
    assign bankOpen = bankOpen_reg;
    assign ck = ck_reg;
    assign ckN = ckN_reg;
    assign csN = csN_reg;
    assign rasN = pins_reg[2];
    assign casN = pins_reg[1];
    assign weN = pins_reg[0];
    assign ba = ba_reg;
    assign addr = addr_reg;
    assign dqOut = dqOut_reg;
    assign dqOe = dqOe_reg;
    assign dqsOut = dqsOut_reg;
    assign dqsOe = dqsOe_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_wr_burst_start;
        !dqOe && dqsOe && !dqsOut ##1 !dqOe && !dqsOut ##1 dqOe && dqsOut ##1 dqOe && !dqsOut;
    endsequence

    a_pre_pattern: assert property (issue && cmdOp == OP_PRE |=>
        !csN && !rasN && casN && !weN && !addr[AP_BIT] && ba == $past(cmdBank))
        else $error("bad single precharge");
    a_preall_a10: assert property (issue && cmdOp == OP_PREALL |=>
        !csN && !rasN && casN && !weN && addr[AP_BIT]) else $error("bad precharge all");
    a_act_pattern: assert property (issue && cmdOp == OP_ACT |=>
        !csN && !rasN && casN && weN ##1 !csN && !rasN) else $error("bad activate");
    a_read_pattern: assert property (issue && cmdOp == OP_READ |=>
        !csN && rasN && !casN && weN) else $error("bad read");
    a_write_data: assert property (issue && cmdOp == OP_WRITE |=>
        s_wr_burst_start) else $error("write data not on time");
    a_write_after_bst: assert property (issue && cmdOp == OP_BST |->
        ##1 !(issue && cmdOp == OP_WRITE) [*3]) else $error("write too soon after stop");
    a_no_write_rdauto: assert property (rdAuto_reg && rdBusy_reg != '0 |->
        !(issue && cmdOp == OP_WRITE)) else $error("write cuts autoprecharge read");
    a_cmd_ack: assert property (issue |=> cmdAck ##1 !cmdAck) else $error("ack missing");
    a_deselect_idle: assert property (slot && !issue |=> csN && rasN && casN && weN)
        else $error("command without request");
endmodule : ddrc_ctrl

// File: pkg/ddrc_pkg.sv
// package: constants, types and functions of the DDR SDRAM command controller
package ddrc_pkg;
    localparam int NUM_BANKS = 4;
    localparam int BA_W = 2;
    localparam int CNT_W = 4;
    localparam int AP_BIT = 10;
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_FIELD_W = 3;
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] CL_CODE_2 = 3'h2;
    localparam logic [2:0] CL_CODE_25 = 3'h6;
    localparam logic [2:0] CL_CODE_3 = 3'h3;
    localparam logic [2:0] BL_RESET = BL_CODE_4;
    localparam logic [2:0] CL_RESET = CL_CODE_25;
    // {ras, cas, we} pin patterns, active low
    localparam logic [2:0] PIN_NOP = 3'h7;
    localparam logic [2:0] PIN_ACT = 3'h3;
    localparam logic [2:0] PIN_RD = 3'h5;
    localparam logic [2:0] PIN_WR = 3'h4;
    localparam logic [2:0] PIN_PRE = 3'h2;
    localparam logic [2:0] PIN_BST = 3'h6;
    localparam logic [2:0] PIN_MRS = 3'h0;
    localparam int CLK_PERIOD_PS = 40000;
    localparam int CK_DIV = 2;
    localparam int CK_PERIOD_PS = CLK_PERIOD_PS * CK_DIV;
    localparam int T_RP_PS = 20000;
    localparam int T_RCD_PS = 20000;
    localparam int T_RAS_PS = 45000;
    localparam int T_RRD_PS = 15000;
    localparam int T_WR_PS = 15000;

    // least times round up to whole CK cycles, never below one
    function automatic int ck_up(input int ps);
        int n;
        n = (ps + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
        return (n < 1) ? 1 : n;
    endfunction : ck_up

    localparam int T_RP_CK = ck_up(T_RP_PS);
    localparam int T_RCD_CK = ck_up(T_RCD_PS);
    localparam int T_RAS_CK = ck_up(T_RAS_PS);
    localparam int T_RRD_CK = ck_up(T_RRD_PS);
    localparam int T_WR_CK = ck_up(T_WR_PS);
    localparam logic [CNT_W-1:0] T_RP_LD = CNT_W'(T_RP_CK - 1);
    localparam logic [CNT_W-1:0] T_RCD_LD = CNT_W'(T_RCD_CK - 1);
    localparam logic [CNT_W-1:0] T_RAS_LD = CNT_W'(T_RAS_CK - 1);
    localparam logic [CNT_W-1:0] T_RRD_LD = CNT_W'(T_RRD_CK - 1);
    localparam logic [CNT_W-1:0] T_WR_CNT = CNT_W'(T_WR_CK);

    typedef enum logic [2:0] {
        OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_PREALL, OP_BST, OP_MRS
    } ddrc_op_t;

    // burst length in CK cycles (half the word count)
    function automatic logic [CNT_W-1:0] burst_ck(input logic [2:0] code);
        case (code)
            BL_CODE_2: return CNT_W'(1);
            BL_CODE_8: return CNT_W'(4);
            default: return CNT_W'(2);
        endcase
    endfunction : burst_ck

    // CAS latency rounded up to whole CK cycles
    function automatic logic [CNT_W-1:0] cl_ru(input logic [2:0] code);
        case (code)
            CL_CODE_2: return CNT_W'(2);
            default: return CNT_W'(3);
        endcase
    endfunction : cl_ru
endpackage : ddrc_pkg

// File: logic/ddrc_bank_timer.sv
// per-bank open state and timing counters, counted in CK slots
`timescale 1ns/1ps
module ddrc_bank_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic slot,
    input wire logic actHit,
    input wire logic preHit,
    input wire logic colHit,
    input wire logic wrHit,
    input wire logic autoHit,
    input wire logic [ddrc_pkg::CNT_W-1:0] wrLd,
    input wire logic [ddrc_pkg::CNT_W-1:0] autoLd,
    output logic isOpen,
    output logic actOk,
    output logic colOk,
    output logic preOk
);
    import ddrc_pkg::*;

    logic open_reg;
    logic auto_reg;
    logic autoFire;
    logic [CNT_W-1:0] rcd_reg;
    logic [CNT_W-1:0] ras_reg;
    logic [CNT_W-1:0] rp_reg;
    logic [CNT_W-1:0] wr_reg;
    logic [CNT_W-1:0] autoCnt_reg;

    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c, input logic s);
        return (s && c != '0) ? c - CNT_W'(1) : c;
    endfunction : step

    // internal precharge of an autoprecharge access, held off by tRAS
    assign autoFire = slot && auto_reg && autoCnt_reg == '0 && ras_reg == '0;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            open_reg <= 1'b0;
        end else if (actHit) begin
            open_reg <= 1'b1;
        end else if (preHit || autoFire) begin
            open_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            auto_reg <= 1'b0;
            autoCnt_reg <= '0;
        end else if (autoHit) begin
            auto_reg <= 1'b1;
            autoCnt_reg <= autoLd;
        end else if (autoFire) begin
            auto_reg <= 1'b0;
        end else begin
            autoCnt_reg <= step(autoCnt_reg, slot);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rcd_reg <= '0;
            ras_reg <= '0;
        end else if (actHit) begin
            rcd_reg <= T_RCD_LD;
            ras_reg <= T_RAS_LD;
        end else begin
            rcd_reg <= step(rcd_reg, slot);
            ras_reg <= step(ras_reg, slot);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rp_reg <= '0;
        end else if (preHit || autoFire) begin
            rp_reg <= T_RP_LD;
        end else begin
            rp_reg <= step(rp_reg, slot);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_reg <= '0;
        end else if (wrHit) begin
            wr_reg <= wrLd;
        end else begin
            wr_reg <= step(wr_reg, slot);
        end
    end

    assign isOpen = open_reg;
    assign actOk = !open_reg && !auto_reg && rp_reg == '0;
    assign colOk = open_reg && !auto_reg && rcd_reg == '0;
    assign preOk = open_reg && !auto_reg && ras_reg == '0 && wr_reg == '0;

    a_act_after_rp: assert property (@(posedge clk) disable iff (reset)
        actHit |-> rp_reg == '0 && !open_reg) else $error("activate before tRP");
    a_col_after_rcd: assert property (@(posedge clk) disable iff (reset)
        colHit |-> open_reg && rcd_reg == '0) else $error("access before tRCD");
    a_pre_after_ras: assert property (@(posedge clk) disable iff (reset)
        (preHit && open_reg) || autoFire |-> ras_reg == '0) else $error("tRAS cut");
    a_pre_after_wr: assert property (@(posedge clk) disable iff (reset)
        preHit && open_reg |-> wr_reg == '0) else $error("write recovery cut");
endmodule : ddrc_bank_timer

// File: logic/ddrc_rd_capture.sv
// read word capture on the device's data strobe, pairs handed over by toggle
`timescale 1ns/1ps
module ddrc_rd_capture #(
    parameter int DQ_W = 8
) (
    input wire logic dqsClk,
    input wire logic reset,
    input wire logic [DQ_W-1:0] dqIn,
    output logic [2*DQ_W-1:0] pairData,
    output logic pairToggle
);
    import ddrc_pkg::*;

    logic [DQ_W-1:0] even_reg;
    logic [2*DQ_W-1:0] pair_reg;
    logic tog_reg;

    // rising strobe edge carries the first word of each pair
    always_ff @(posedge dqsClk or posedge reset) begin
        if (reset) begin
            even_reg <= '0;
        end else begin
            even_reg <= dqIn;
        end
    end

    // falling edge completes the pair; data holds until the next pair
    always_ff @(negedge dqsClk or posedge reset) begin
        if (reset) begin
            pair_reg <= '0;
            tog_reg <= 1'b0;
        end else begin
            pair_reg <= {dqIn, even_reg};
            tog_reg <= ~tog_reg;
        end
    end

    assign pairData = pair_reg;
    assign pairToggle = tog_reg;
endmodule : ddrc_rd_capture

// File: sim/ddrc_dev_model.sv
// behavioural four-bank DDR SDRAM: command decode, bank state, burst data
`timescale 1ns/1ps
module ddrc_dev_model
    import ddrc_pkg::*;
(
    input wire logic ck,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic [7:0] dqOut,
    input wire logic dqsOut,
    input wire logic dqsOe,
    output logic [7:0] dqIn,
    output logic dqsClk
);
    logic [7:0] mem [256];
    logic [3:0] openReg = 4'h0;
    logic [7:0] wa;
    int wc = 4;
    initial {dqIn, dqsClk} = 9'h000;
    // data strobe stands still between bursts, released data inverts
    task automatic burst(input logic [7:0] a);
        #193;
        for (int i = 0; i < 4; i += 2) begin
            dqIn = mem[8'(a + i)];
            #40 dqsClk = 1'b1;
            #40 dqIn = mem[8'(a + i + 1)];
            #40 dqsClk = 1'b0;
            #40;
        end
        dqIn = ~dqIn;
    endtask : burst
    always @(posedge ck) begin
        if (!csN) begin
            case ({rasN, casN, weN})
                PIN_ACT: openReg[ba] <= 1'b1;
                PIN_PRE: openReg <= addr[AP_BIT] ? 4'h0 : openReg & ~(4'h1 << ba);
                PIN_WR: {wa, wc} = {addr[7:0], 32'h0};
                PIN_RD: fork burst(addr[7:0]); join_none
                default: ;
            endcase
        end
    end
    always @(dqsOut) if (dqsOe === 1'b1 && wc < 4) begin
        mem[8'(wa + wc)] = dqOut;
        wc++;
    end
endmodule : ddrc_dev_model

// File: sim/tb_top.sv
// testbench: user-side stimulus and scoreboard for the DDR command controller
`timescale 1ns/1ps
module tb_top;
    import ddrc_pkg::*;
    logic clk = 0, reset = 1, cmdValid = 0, cmdAuto = 0, ck, ckN, csN, rasN, casN, weN;
    logic cmdAck, wrPull, rdValid, dqOe, dqsOe, dqsOut, dqsClk;
    ddrc_op_t cmdOp = OP_NOP;
    logic [1:0] cmdBank = 0, ba;
    logic [12:0] cmdAddr = 0, addr;
    logic [7:0] wrData = 0, dqOut, dqIn, sh [256], wd [64];
    logic [15:0] rdData, exp [$];
    logic [3:0] bankOpen;
    int fails = 0, checks = 0, wi = 0, wn = 0, cyc = 0, ackCyc = 0, t0 = 0;
    always #20 clk = ~clk;
    ddrc_ctrl uut (.*);
    ddrc_dev_model dev (.*);
    task automatic chk(input string nm, input logic [15:0] seen, want);
        checks++;
        if (seen !== want) begin
            fails++;
            $display("BAD %s want %h seen %h", nm, want, seen);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        wrData <= wd[wi + wrPull];
        wi <= wi + wrPull;
        cyc <= cyc + 1;
    end
    always @(posedge clk) if (rdValid === 1'b1) chk("rdData", rdData, exp.size() ? exp.pop_front() : 'x);
    task automatic cmd(input ddrc_op_t op, input int b, c, input logic au, input logic [2:0] pat,
            input logic a10);
        int n;
        logic [15:0] pv;
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdBank <= 2'(b);
        cmdAddr <= 13'(c);
        cmdAuto <= au;
        for (n = 0; n < 200; n++) begin
            @(negedge clk);
            if (cmdAck === 1'b1) begin
                ackCyc = cyc;
                break;
            end
        end
        pv = 16'({ba, csN, rasN, casN, weN, addr[AP_BIT], ckN ^ ck});
        chk("pins", pv, 16'({2'(b), 1'b0, pat, a10, 1'b1}));
        @(posedge clk);
        cmdValid <= 1'b0;
    endtask : cmd
    task automatic wr(input int c);
        for (int k = 0; k < 4; k++) sh[8'(c + k)] = wd[wn + k];
        wn += 4;
        cmd(OP_WRITE, c / 16, c, 1'b0, PIN_WR, 1'b0);
        repeat (8) @(posedge clk);
    endtask : wr
    task automatic rd(input int c, input logic au);
        int n;
        exp.push_back({sh[8'(c + 1)], sh[8'(c)]});
        exp.push_back({sh[8'(c + 3)], sh[8'(c + 2)]});
        cmd(OP_READ, c / 16, c, au, PIN_RD, au);
        for (n = 0; n < 100 && exp.size() > 0; n++) @(posedge clk);
        chk("rdLeft", 16'(exp.size()), 16'h0000);
        repeat (4) @(posedge clk);
    endtask : rd
    initial begin
        #400000;
        fails++;
        close_out();
    end
    initial begin
        void'($urandom(32'h5714));
        foreach (wd[k]) wd[k] = 8'($urandom);
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            cmd(OP_ACT, b, 13'h1A5, 1'b0, PIN_ACT, 1'b0);
            wr(b * 16 + 4);
            rd(b * 16 + 4, 1'b0);
            chk("open", 16'(bankOpen), 16'(4'hF >> (3 - b)));
        end
        $display("test open write read done");
        cmd(OP_PRE, 1, 0, 1'b0, PIN_PRE, 1'b0);
        repeat (4) @(posedge clk);
        chk("open", 16'(bankOpen), 16'h000D);
        cmd(OP_PREALL, 0, 0, 1'b0, PIN_PRE, 1'b1);
        repeat (4) @(posedge clk);
        chk("open", 16'(bankOpen), 16'h0000);
        $display("test precharge done");
        cmd(OP_ACT, 2, 13'h1A5, 1'b0, PIN_ACT, 1'b0);
        rd(36, 1'b1);
        chk("open", 16'(bankOpen), 16'h0000);
        $display("test autoprecharge done");
        cmd(OP_ACT, 1, 13'h1A5, 1'b0, PIN_ACT, 1'b0);
        exp.push_back({sh[21], sh[20]});
        exp.push_back({sh[23], sh[22]});
        cmd(OP_READ, 1, 20, 1'b0, PIN_RD, 1'b0);
        cmd(OP_BST, 1, 0, 1'b0, PIN_BST, 1'b0);
        t0 = ackCyc;
        wr(24);
        chk("bstGap", 16'(ackCyc - t0), 16'(3 * CK_DIV));
        rd(24, 1'b0);
        $display("test burst stop done");
        close_out();
    end
endmodule : tb_top
